// >>> rtl/sensor_interrupt_enable_logic.sv
// interrupt enable registers, flag registers, read port and interrupt output of the sensor
`timescale 1ns/1ps
`include "irq_map.svh"

module sensor_interrupt_enable_logic (
    input  wire logic                  clk,
    input  wire logic                  reset,
    input  wire irq_pkg::reg_access_s  reg_wr,         // generic register write
    input  wire irq_pkg::reg_access_s  reg_rd,         // register_read_command
    input  wire logic                  irq_rd,         // dedicated interrupt read, pulse
    input  wire irq_pkg::flag_idx_t    irq_rd_sel,     // flag register picked by irq_rd
    input  wire logic                  service_unlock, // true write mode for flags
    input  wire logic                  interrupt_mode, // 0 accumulate, 1 overwrite
    input  wire logic                  seq_start,      // start a measurement run
    input  wire irq_pkg::conv_events_s conv_ev,        // converter done events
    input  wire logic [15:0]           primary_cond,   // conditions for the primary flags
    input  wire logic [15:0]           detail_cond,    // conditions for the error details
    input  wire logic [15:0]           sensor_chk,     // bridge diagnostic result
    output logic                       start_t1,       // start temperature conversion
    output logic                       start_p,        // start pressure conversion
    output logic                       start_comp,     // start compensation
    output logic                       seq_busy,       // run in progress
    output logic [15:0]                rd_data,        // read data, registered
    output logic                       rd_valid,       // read data valid, pulse
    output logic                       irq             // interrupt output, registered
);
    import irq_pkg::*;

    localparam int NFLAG = 3;   // primary, error detail, bridge diagnostic

    // address hit, used by the write and read decoders
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // ---------------- enable registers ----------------
    logic [15:0] en_q [NFLAG];   // stored enables
    logic [15:0] en_d [NFLAG];   // next enables
    logic [7:0]  en_ofs [NFLAG]; // enable offsets
    logic [7:0]  fl_ofs [NFLAG]; // flag offsets

    assign en_ofs[0] = `OFS_PRIMARY_IRQ_ENABLE;
    assign en_ofs[1] = `OFS_ERROR_DETAIL_IRQ_ENABLE;
    assign en_ofs[2] = `OFS_BRIDGE_DIAG_IRQ_ENABLE;
    assign fl_ofs[0] = `OFS_PRIMARY_FLAGS;
    assign fl_ofs[1] = `OFS_ERROR_DETAIL_FLAGS;
    assign fl_ofs[2] = `OFS_BRIDGE_DIAG_FLAGS;

    // enable writes store the whole word; no side effects
    always_comb begin
        for (int i = 0; i < NFLAG; i++) begin
            en_d[i] = en_q[i];
            if (reg_wr.en && hit(reg_wr.addr, en_ofs[i])) begin
                en_d[i] = reg_wr.data;
            end
        end
    end

    // register only; nothing is enabled out of reset so no stale flag fires
    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < NFLAG; i++) begin
                en_q[i] <= `RST_IRQ_ENABLE;
            end
        end else begin
            for (int i = 0; i < NFLAG; i++) begin
                en_q[i] <= en_d[i];
            end
        end
    end

    // ---------------- conversion sequence ----------------
    logic eval;     // end of the whole run, one cycle

    conversion_sequencer u_seq (
        .clk        (clk),
        .reset      (reset),
        .seq_start  (seq_start),
        .ev         (conv_ev),
        .start_t1   (start_t1),
        .start_p    (start_p),
        .start_comp (start_comp),
        .eval       (eval),
        .busy       (seq_busy)
    );

    // ---------------- flag update masks ----------------
    logic [15:0] upd   [NFLAG];  // bits evaluated this cycle
    logic [15:0] cond  [NFLAG];  // condition word per register
    logic [15:0] flags [NFLAG];  // current flags
    logic [15:0] diag_upd;       // diagnostic slice mask

    // diagnostics follow each conversion's end, not the sequence end,
    // so a bridge fault is seen as early as possible
    always_comb begin
        diag_upd = 16'h0000;
        if (conv_ev.t2_done) begin
            diag_upd = diag_upd | `MASK_DIAG_SECOND_TEMP;
        end
        if (conv_ev.t1_done) begin
            diag_upd = diag_upd | `MASK_DIAG_FIRST_TEMP;
        end
        if (conv_ev.p_done) begin
            diag_upd = diag_upd | `MASK_DIAG_PRESSURE;
        end
    end

    // all other flags, including the temperature limits, wait for the end of the run
    assign upd[0]  = eval ? 16'hffff : 16'h0000;
    assign upd[1]  = eval ? 16'hffff : 16'h0000;
    assign upd[2]  = diag_upd;
    assign cond[0] = primary_cond;
    assign cond[1] = detail_cond;
    assign cond[2] = sensor_chk;

    // ---------------- flag registers ----------------
    // the same clear or true-write logic serves all three flag words
    genvar g;
    generate
        for (g = 0; g < NFLAG; g++) begin : gen_flags
            logic fwr;      // host write to this flag word
            assign fwr = reg_wr.en && hit(reg_wr.addr, fl_ofs[g]);
            flag_register #(
                .WIDTH (16)
            ) u_flag (
                .clk      (clk),
                .reset    (reset),
                .wr       (fwr),
                .wdata    (reg_wr.data),
                .unlock   (service_unlock),
                .mode     (interrupt_mode),
                .upd_mask (upd[g]),
                .cond     (cond[g]),
                .flags    (flags[g])
            );
        end
    endgenerate

    // ---------------- read port ----------------
    logic [15:0] rd_data_q;  // stored read data
    logic [15:0] rd_data_d;  // next read data
    logic        rd_valid_q; // stored valid
    logic        rd_valid_d; // next valid

    // both read paths land on the same flag storage, so they cannot disagree;
    // the dedicated read wins if both arrive together, since it cannot be retried
    always_comb begin
        rd_data_d  = rd_data_q;
        rd_valid_d = 1'b0;
        if (irq_rd) begin
            rd_valid_d = 1'b1;
            if (irq_rd_sel < 2'(NFLAG)) begin
                rd_data_d = flags[irq_rd_sel];
            end else begin
                rd_data_d = 16'h0000;               // no fourth flag word
            end
        end else if (reg_rd.en) begin
            rd_valid_d = 1'b1;
            rd_data_d  = 16'h0000;                  // unmapped reads as zero
            for (int i = 0; i < NFLAG; i++) begin
                if (hit(reg_rd.addr, fl_ofs[i])) begin
                    rd_data_d = flags[i];
                end
                if (hit(reg_rd.addr, en_ofs[i])) begin
                    rd_data_d = en_q[i];
                end
            end
        end
    end

    // register only
    always_ff @(posedge clk) begin
        if (reset) begin
            rd_data_q  <= 16'h0000;
            rd_valid_q <= 1'b0;
        end else begin
            rd_data_q  <= rd_data_d;
            rd_valid_q <= rd_valid_d;
        end
    end

    assign rd_data  = rd_data_q;
    assign rd_valid = rd_valid_q;

    // ---------------- interrupt output ----------------
    logic irq_q;        // registered output
    logic irq_d;        // next output
    logic plain_hit;    // an ungrouped enabled flag
    logic detail_hit;   // an enabled error detail
    logic diag_hit;     // an enabled bridge diagnostic
    logic group_hit;    // a fully enabled grouped error

    // a grouped bit counts only when its detail or diagnostic word is also enabled; each flag word clears
    // on its own, so the host can clear details and the group bit in either order
    always_comb begin
        // bit 15 of the primary word is the global enable position, not a source
        plain_hit  = |(flags[0] & en_q[0] & ~`MASK_GROUPED & 16'h7fff);
        detail_hit = |(flags[1] & en_q[1]);
        diag_hit   = |(flags[2] & en_q[2]);
        group_hit  = (flags[0][`BIT_ADC_ERROR] & en_q[0][`BIT_ADC_ERROR] & detail_hit)
                   | (flags[0][`BIT_CALC_ERROR] & en_q[0][`BIT_CALC_ERROR] & detail_hit)
                   | (flags[0][`BIT_SENSOR_ERROR] & en_q[0][`BIT_SENSOR_ERROR]
                      & diag_hit);
        irq_d      = en_q[0][`BIT_GENERAL_INT_EN] & (plain_hit | group_hit);
    end

    // register only; one cycle late but glitch free on the pin
    always_ff @(posedge clk) begin
        if (reset) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end

    assign irq = irq_q;

endmodule : sensor_interrupt_enable_logic

// >>> rtl/irq_map.svh
// register offsets, field positions, reset values and field boundaries of the interrupt logic
`ifndef IRQ_MAP_SVH
`define IRQ_MAP_SVH

// enable registers
`define OFS_PRIMARY_IRQ_ENABLE      8'h73
`define OFS_ERROR_DETAIL_IRQ_ENABLE 8'h74
`define OFS_BRIDGE_DIAG_IRQ_ENABLE  8'h75

// flag registers
`define OFS_PRIMARY_FLAGS           8'h80
`define OFS_ERROR_DETAIL_FLAGS      8'h81
`define OFS_BRIDGE_DIAG_FLAGS       8'h82

// reset values
`define RST_IRQ_ENABLE              16'h0000
`define RST_FLAGS                   16'h0000

// primary enable / flag field positions
`define BIT_GENERAL_INT_EN          15
`define BIT_ADC_ERROR               8
`define BIT_CALC_ERROR              7
`define BIT_SENSOR_ERROR            6

// grouped bits of the primary register, one mask
`define MASK_GROUPED                16'h01c0

// bridge diagnostic update slices
`define MASK_DIAG_SECOND_TEMP       16'he000
`define MASK_DIAG_FIRST_TEMP        16'h1c00
`define MASK_DIAG_PRESSURE          16'h03ff

`endif

// >>> rtl/irq_pkg.sv
// types shared by the interrupt enable and flag logic
package irq_pkg;

    // one register access from the command decoder
    typedef struct packed {
        logic        en;    // one-cycle strobe
        logic [7:0]  addr;  // register address
        logic [15:0] data;  // write data, unused on reads
    } reg_access_s;

    // conversion engine done events, one-cycle pulses
    typedef struct packed {
        logic t1_done;      // first_temperature_channel finished
        logic t2_done;      // second_temperature_channel finished
        logic p_done;       // pressure conversion finished
        logic comp_done;    // compensation computation finished
    } conv_events_s;

    // sequencer states, one-hot
    typedef enum logic [4:0] {
        SEQ_IDLE = 5'b00001,
        SEQ_T1   = 5'b00010,
        SEQ_P    = 5'b00100,
        SEQ_COMP = 5'b01000,
        SEQ_EVAL = 5'b10000
    } seq_state_e;

    // flag register index
    typedef logic [1:0] flag_idx_t;

endpackage : irq_pkg

// >>> rtl/flag_register.sv
// one 16-bit interrupt flag register: host clear or true write, then hardware update
`timescale 1ns/1ps
module flag_register #(
    parameter int WIDTH = 16
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             wr,         // host write strobe for this register
    input  wire logic [WIDTH-1:0] wdata,      // host write data
    input  wire logic             unlock,     // service unlock mode
    input  wire logic             mode,       // 0 accumulate, 1 overwrite
    input  wire logic [WIDTH-1:0] upd_mask,   // bits evaluated this cycle
    input  wire logic [WIDTH-1:0] cond,       // current conditions
    output logic      [WIDTH-1:0] flags       // registered flag value
);
    import irq_pkg::*;

    logic [WIDTH-1:0] flags_q;  // stored flags
    logic [WIDTH-1:0] flags_d;  // next flags
    logic [WIDTH-1:0] base;     // value after the host write

    // host write first, hardware update second, so a new event beats a clear
    always_comb begin
        base = flags_q;
        if (wr) begin
            if (unlock) begin
                base = wdata;
            end else begin
                base = flags_q & ~wdata;
            end
        end
        if (mode) begin
            flags_d = (base & ~upd_mask) | (cond & upd_mask);
        end else begin
            flags_d = base | (cond & upd_mask);
        end
    end

    // register only
    always_ff @(posedge clk) begin
        if (reset) begin
            flags_q <= WIDTH'(`RST_FLAGS);
        end else begin
            flags_q <= flags_d;
        end
    end

    assign flags = flags_q;

endmodule : flag_register

// >>> rtl/conversion_sequencer.sv
// orders a temperature, pressure, compensation run and signals the flag evaluation
`timescale 1ns/1ps
module conversion_sequencer (
    input  wire logic                 clk,
    input  wire logic                 reset,
    input  wire logic                 seq_start,   // request a new run, pulse
    input  wire irq_pkg::conv_events_s ev,         // done events from the converters
    output logic                      start_t1,    // start temperature conversion, pulse
    output logic                      start_p,     // start pressure conversion, pulse
    output logic                      start_comp,  // start compensation, pulse
    output logic                      eval,        // evaluate flags, pulse
    output logic                      busy         // run in progress
);
    import irq_pkg::*;

    seq_state_e state_q;       // current step
    seq_state_e state_d;       // next step
    logic       start_t1_d;    // next start pulses
    logic       start_p_d;
    logic       start_comp_d;
    logic       start_t1_q;
    logic       start_p_q;
    logic       start_comp_q;

    // the temperature, pressure and compensation steps each wait for their own done event; a start during a run is ignored
    always_comb begin
        state_d      = state_q;
        start_t1_d   = 1'b0;
        start_p_d    = 1'b0;
        start_comp_d = 1'b0;
        case (state_q)
            SEQ_IDLE: begin
                if (seq_start) begin
                    state_d    = SEQ_T1;
                    start_t1_d = 1'b1;
                end
            end
            SEQ_T1: begin
                if (ev.t1_done) begin
                    state_d   = SEQ_P;
                    start_p_d = 1'b1;
                end
            end
            SEQ_P: begin
                if (ev.p_done) begin
                    state_d      = SEQ_COMP;
                    start_comp_d = 1'b1;
                end
            end
            SEQ_COMP: begin
                if (ev.comp_done) begin
                    state_d = SEQ_EVAL;
                end
            end
            SEQ_EVAL: begin
                state_d = SEQ_IDLE;                 // evaluation lasts one cycle
            end
            default: begin
                state_d = SEQ_IDLE;
            end
        endcase
    end

    // register only
    always_ff @(posedge clk) begin
        if (reset) begin
            state_q      <= SEQ_IDLE;
            start_t1_q   <= 1'b0;
            start_p_q    <= 1'b0;
            start_comp_q <= 1'b0;
        end else begin
            state_q      <= state_d;
            start_t1_q   <= start_t1_d;
            start_p_q    <= start_p_d;
            start_comp_q <= start_comp_d;
        end
    end

    assign start_t1   = start_t1_q;
    assign start_p    = start_p_q;
    assign start_comp = start_comp_q;
    assign eval       = (state_q == SEQ_EVAL);
    assign busy       = (state_q != SEQ_IDLE);

endmodule : conversion_sequencer

// >>> verification/conv_model.sv
// converter model: answers each start pulse with its done event after a set delay
`timescale 1ns/1ps
module conv_model (
    input  wire logic           clk,
    input  wire logic           reset,
    input  wire logic           start_t1,
    input  wire logic           start_p,
    input  wire logic           start_comp,
    input  wire logic           t2_on,  // also report the second temperature channel
    input  wire logic [3:0]     dly,    // answer delay in cycles, prompt or slow
    output irq_pkg::conv_events_s ev
);
    import irq_pkg::*;
    logic [3:0] cnt;   // cycles left until the done event
    logic [2:0] kind;  // which conversion is running

    // done events are one-cycle pulses, like a real converter; only one job runs at a time
    always @(posedge clk) begin
        ev <= '0;
        if (reset) begin
            cnt <= 4'h0;
        end else if (start_t1 || start_p || start_comp) begin
            cnt  <= dly;
            kind <= {start_comp, start_p, start_t1};
        end else if (cnt == 4'h1) begin
            ev.t1_done   <= kind[0];
            ev.t2_done   <= kind[0] & t2_on;
            ev.p_done    <= kind[1];
            ev.comp_done <= kind[2];
            cnt          <= 4'h0;
        end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end
    end
endmodule : conv_model

// >>> verification/sensor_irq_properties.sv
// concurrent checks on the ports of the interrupt enable and flag logic
`timescale 1ns/1ps
module sensor_irq_properties (
    input wire logic                  clk,
    input wire logic                  reset,
    input wire irq_pkg::reg_access_s  reg_wr,
    input wire irq_pkg::reg_access_s  reg_rd,
    input wire logic                  irq_rd,
    input wire irq_pkg::flag_idx_t    irq_rd_sel,
    input wire logic                  seq_start,
    input wire logic                  start_t1,
    input wire logic                  start_p,
    input wire logic                  start_comp,
    input wire logic                  seq_busy,
    input wire logic [15:0]           rd_data,
    input wire logic                  rd_valid,
    input wire logic                  irq
);
    import irq_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_reset_quiet: assert property ($fell(reset) |-> !irq && !rd_valid && !seq_busy)
        else $error("outputs not idle after reset");
    a_read_answer: assert property ((reg_rd.en || irq_rd) |=> rd_valid)
        else $error("read not answered next cycle");
    a_valid_cause: assert property (rd_valid |-> $past(reg_rd.en) || $past(irq_rd))
        else $error("read valid without a read");
    a_unmapped_zero: assert property (reg_rd.en && !irq_rd && !(reg_rd.addr inside
        {8'h73, 8'h74, 8'h75, 8'h80, 8'h81, 8'h82}) |=> rd_data == 16'h0000)
        else $error("unmapped read not zero");
    a_sel_three: assert property (irq_rd && irq_rd_sel == 2'h3 |=> rd_data == 16'h0000)
        else $error("interrupt read of slot three not zero");
    a_seq_first: assert property (seq_start && !seq_busy |=> start_t1 && seq_busy)
        else $error("run did not begin with temperature");
    a_busy_rise: assert property ($rose(seq_busy) |-> start_t1)
        else $error("busy rose without temperature start");
    a_start_order: assert property (start_p |-> seq_busy && !start_t1 && !start_comp)
        else $error("pressure start out of order");
    a_comp_pulse: assert property (start_comp |=> !start_comp)
        else $error("compensation start longer than a pulse");
    a_global_off: assert property (reg_wr.en && reg_wr.addr == 8'h73 && !reg_wr.data[15]
        |-> ##2 !irq)
        else $error("interrupt high with global enable off");
endmodule : sensor_irq_properties

bind sensor_interrupt_enable_logic sensor_irq_properties u_props (.clk, .reset, .reg_wr,
    .reg_rd, .irq_rd, .irq_rd_sel, .seq_start, .start_t1, .start_p, .start_comp, .seq_busy,
    .rd_data, .rd_valid, .irq);

// >>> verification/test_sensor_interrupt_enable_logic.sv
// self-checking bench for the interrupt enable and flag logic
`timescale 1ns/1ps
module test_sensor_interrupt_enable_logic;
    import irq_pkg::*;
    logic         clk, reset, irq_rd, service_unlock, interrupt_mode, seq_start, t2_on;
    reg_access_s  reg_wr, reg_rd;
    flag_idx_t    irq_rd_sel;
    conv_events_s conv_ev;
    logic [15:0]  primary_cond, detail_cond, sensor_chk, rd_data;
    logic         start_t1, start_p, start_comp, seq_busy, rd_valid, irq;
    logic [3:0]   dly;
    logic [15:0]  f0, f1, f2, e0, e1, e2, d, m;  // expected flag and enable words
    int           seed, mismatches, compares, cycles, i, k;

    sensor_interrupt_enable_logic dut (.clk, .reset, .reg_wr, .reg_rd, .irq_rd, .irq_rd_sel,
        .service_unlock, .interrupt_mode, .seq_start, .conv_ev, .primary_cond, .detail_cond,
        .sensor_chk, .start_t1, .start_p, .start_comp, .seq_busy, .rd_data, .rd_valid, .irq);
    conv_model u_conv (.clk, .reset, .start_t1, .start_p, .start_comp, .t2_on, .dly,
        .ev(conv_ev));

    // free-running clock, 50 ns period
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            close_out();
        end
    end

    task automatic close_out();
        $display("counts: %0d compares, %0d mismatches", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : close_out

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // inputs always move 2 ns after the rising edge
    task automatic step();
        @(posedge clk);
        #2;
    endtask : step

    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        step();
        reg_wr = '{1'b1, a, v};
        step();
        reg_wr.en = 1'b0;
    endtask : wr

    // answer is registered at the taking edge; rd_valid stands for the one cycle after it only, rd_data holds until the next read
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        step();
        reg_rd = '{1'b1, a, 16'h0000};
        step();
        reg_rd.en = 1'b0;
        check({15'h0, rd_valid}, 16'h0001);
        check(rd_data, e);
    endtask : rd

    task automatic ird(input flag_idx_t s, input logic [15:0] e);
        step();
        irq_rd = 1'b1;
        irq_rd_sel = s;
        step();
        irq_rd = 1'b0;
        check({15'h0, rd_valid}, 16'h0001);
        check(rd_data, e);
    endtask : ird

    // one full run; primary flags must not move before the compensation has finished
    task automatic run_seq();
        dly = 4'h8 + 4'($random(seed) & 7);
        step();
        seq_start = 1'b1;
        step();
        seq_start = 1'b0;
        for (i = 0; i < 200 && start_comp !== 1'b1; i++) step();
        rd(8'h80, f0);
        for (i = 0; i < 200 && seq_busy !== 1'b0; i++) step();
        repeat (3) step();
    endtask : run_seq

    // interrupt level expected from enables and flags; grouped bits need their detail or diagnostic word
    function automatic logic exp_irq(input logic [15:0] a0, a1, a2, g0, g1, g2);
        logic grp;
        grp = ((g0[8] & a0[8]) | (g0[7] & a0[7])) & |(g1 & a1);
        grp = grp | (g0[6] & a0[6] & |(g2 & a2));
        return a0[15] & (|(g0 & a0 & ~16'h81c0) | grp);
    endfunction : exp_irq

    initial begin
        seed = 32'h639beacc;
        reset = 1'b1;
        reg_wr = '0;
        reg_rd = '0;
        {irq_rd, irq_rd_sel, service_unlock, interrupt_mode, seq_start, t2_on} = '0;
        {primary_cond, detail_cond, sensor_chk, f0, f1, f2} = '0;
        dly = 4'h8;
        {mismatches, compares, cycles} = '0;
        repeat (5) @(posedge clk);
        #2 reset = 1'b0;
        rd(8'h73, 16'h0000);
        rd(8'h74, 16'h0000);
        rd(8'h75, 16'h0000);
        rd(8'h80, 16'h0000);
        rd(8'h90, 16'h0000);
        $display("test reset_values done");
        // two accumulating runs, then two overwriting runs, second channel on every other
        for (k = 0; k < 4; k++) begin
            interrupt_mode = (k > 1);
            t2_on = k[0];
            m = t2_on ? 16'hffff : 16'h1fff;
            primary_cond = $random(seed) & 16'h7fff;
            detail_cond = $random(seed);
            sensor_chk = $random(seed);
            run_seq();
            f0 = interrupt_mode ? primary_cond : f0 | primary_cond;
            f1 = interrupt_mode ? detail_cond : f1 | detail_cond;
            f2 = interrupt_mode ? (f2 & ~m) | (sensor_chk & m) : f2 | (sensor_chk & m);
            rd(8'h80, f0);
            rd(8'h81, f1);
            rd(8'h82, f2);
            ird(2'h0, f0);
        end
        $display("test evaluation done");
        service_unlock = 1'b1;
        f0 = ($random(seed) & 16'h7fff) | 16'h0005;
        wr(8'h80, f0);
        rd(8'h80, f0);
        ird(2'h0, f0);
        ird(2'h3, 16'h0000);
        service_unlock = 1'b0;
        d = $random(seed);
        wr(8'h82, d);
        wr(8'h81, d);
        wr(8'h80, 16'h0005);
        rd(8'h80, f0 & ~16'h0005);
        rd(8'h81, f1 & ~d);
        rd(8'h82, f2 & ~d);
        $display("test flag_clear done");
        // random enables and flags, grouped-only corners first
        service_unlock = 1'b1;
        for (k = 0; k < 24; k++) begin
            e0 = $random(seed);
            e1 = $random(seed) & $random(seed);
            e2 = $random(seed) & $random(seed);
            f0 = $random(seed) & $random(seed) & 16'h7fff;
            f1 = $random(seed) & $random(seed);
            f2 = $random(seed) & $random(seed);
            if (k < 8) e0 = 16'h8000 | (e0 & 16'h01c0);
            if (k < 3) {e1, e2} = '0;
            wr(8'h73, e0);
            wr(8'h74, e1);
            wr(8'h75, e2);
            wr(8'h80, f0);
            wr(8'h81, f1);
            wr(8'h82, f2);
            step();
            step();
            check({15'h0, irq}, {15'h0, exp_irq(e0, e1, e2, f0, f1, f2)});
        end
        rd(8'h73, e0);
        // flag bit 15 alone must never raise the output
        wr(8'h73, 16'h8000);
        wr(8'h80, 16'h8000);
        step();
        step();
        check({15'h0, irq}, 16'h0000);
        $display("test irq_gating done");
        close_out();
    end
endmodule : test_sensor_interrupt_enable_logic
